// file: rtl/bpc_host.sv
// host controller issuing block-protection command sequences to a parallel flash
`timescale 1ns/10ps
`default_nettype none
module bpc_host
    import bpc_pkg::*;
#(
    parameter int UNLOCK_GAP = UNLOCK_GAP_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [25:0] flash_addr,
    output logic      [15:0] flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_we_n,
    output logic             flash_oe_n
);
    import bpc_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_GAP    = 4'b1000
    } bpc_state_t;

    // ************************
    // state
    // ************************
    bpc_state_t  state_q;
    logic [31:0] ctrl_q, addr_q, wdata_q;
    logic [15:0] rdata_q;
    logic [15:0] pw_q [4];
    logic [2:0]  step_q, nsteps_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] gap_q;
    logic        busy_q, refused_q;
    logic        cyc_rd;
    logic [25:0] cyc_a;
    logic [15:0] cyc_d;

    // per-step address/data/direction of the current operation
    function automatic logic [42:0] seq_step(input logic [3:0] op, input logic [2:0] st,
                                            input logic [31:0] a, input logic [15:0] d,
                                            input logic [7:0] code, input logic [15:0] pw [4]);
        logic [42:0] r;
        r = {1'b0, 26'h0, 16'h0};
        case (op)
            OP_ENTER: begin
                if (st == 3'd0) r = {1'b0, 10'h0, ADR_UNLOCK1, DAT_UNLOCK1};
                else if (st == 3'd1) r = {1'b0, 10'h0, ADR_UNLOCK2, DAT_UNLOCK2};
                else r = {1'b0, 10'h0, ADR_UNLOCK1, 8'h00, code};
            end
            OP_PROG: begin
                if (st == 3'd0) r = {1'b0, 26'h0, DAT_PROGRAM};
                else r = {1'b0, a[25:0], d};
            end
            OP_READ:   r = {1'b1, a[25:0], 16'h0};
            OP_EXIT:   r = (st == 3'd0) ? {1'b0, 26'h0, DAT_EXIT1} : {1'b0, 26'h0, DAT_EXIT2};
            OP_CLRALL: r = (st == 3'd0) ? {1'b0, 26'h0, DAT_CLRALL1} : {1'b0, 10'h0, ADR_ZERO, DAT_CLRALL2};
            OP_UNLOCK: begin
                if (st == 3'd0) r = {1'b0, 26'h0, DAT_UNLK1};
                else if (st == 3'd1) r = {1'b0, 26'h0, DAT_UNLK2};
                else if (st == 3'd6) r = {1'b0, 26'h0, DAT_UNLK_END};
                else r = {1'b0, 24'h0, 2'(st - 3'd2), pw[2'(st - 3'd2)]};
            end
            default:   r = {1'b0, a[25:0], d};
        endcase
        return r;
    endfunction : seq_step

    function automatic logic [2:0] op_len(input logic [3:0] op);
        case (op)
            OP_ENTER:  return 3'd3;
            OP_READ:   return 3'd1;
            OP_RAW_WR: return 3'd1;
            OP_UNLOCK: return 3'd7;
            default:   return 3'd2;
        endcase
    endfunction : op_len

    // password word window; write decode and read mux must agree on it
    function automatic logic pw_hit(input logic [7:0] a);
        return (a >= OFF_PW0) && (a < OFF_PW0 + 8'h10);
    endfunction : pw_hit

    assign {cyc_rd, cyc_a, cyc_d} = seq_step(ctrl_q[3:0], step_q, addr_q, wdata_q[15:0], ctrl_q[15:8], pw_q);

    // ************************
    // apb slave, zero wait state
    // ************************
    wire wr_en = psel && penable && pwrite;
    wire start = wr_en && paddr == OFF_CTRL && !busy_q;
    wire unlock_early = (pwdata[3:0] == OP_UNLOCK) && (gap_q != '0);
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // register writes; go is refused while busy, and an unlock go is refused too soon after an unlock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= CTRL_RESET;
            addr_q    <= 32'h0;
            wdata_q   <= 32'h0;
            refused_q <= 1'b0;
            for (int i = 0; i < 4; i++) pw_q[i] <= 16'hffff;
        end else if (wr_en) begin
            if (paddr == OFF_CTRL) begin
                if (start && !unlock_early) ctrl_q <= pwdata;
                refused_q <= !start || unlock_early;
            end else if (paddr == OFF_ADDR) addr_q <= pwdata;
            else if (paddr == OFF_WDATA) wdata_q <= pwdata;
            else if (pw_hit(paddr)) pw_q[paddr[3:2] - 2'd1] <= pwdata[15:0];
        end
    end

    // read mux
    always_comb begin
        prdata = 32'h0;
        if (paddr == OFF_CTRL) prdata = ctrl_q;
        else if (paddr == OFF_ADDR) prdata = addr_q;
        else if (paddr == OFF_WDATA) prdata = wdata_q;
        else if (paddr == OFF_STATUS) prdata = {29'h0, gap_q != '0, refused_q, busy_q};
        else if (paddr == OFF_RDATA) prdata = {16'h0, rdata_q};
        else if (pw_hit(paddr)) prdata = {16'h0, pw_q[paddr[3:2] - 2'd1]};
    end

    // ************************
    // bus cycle sequencer
    // ************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= ST_IDLE;
            busy_q   <= 1'b0;
            step_q   <= 3'd0;
            nsteps_q <= 3'd0;
            cnt_q    <= '0;
        end else begin
            case (state_q)
                ST_IDLE: if (start && !unlock_early && pwdata[3:0] != 4'h0) begin
                    busy_q   <= 1'b1;
                    step_q   <= 3'd0;
                    nsteps_q <= op_len(pwdata[3:0]);
                    state_q  <= ST_SETUP;
                end
                ST_SETUP: begin
                    cnt_q   <= CNT_W'(STROBE_CYC);
                    state_q <= ST_STROBE;
                end
                ST_STROBE: if (cnt_q == 1) begin
                    cnt_q   <= CNT_W'(IDLE_CYC);
                    state_q <= ST_GAP;
                end else cnt_q <= cnt_q - 1'b1;
                ST_GAP: if (cnt_q == 1) begin
                    if (step_q + 3'd1 == nsteps_q) begin
                        busy_q  <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        step_q  <= step_q + 3'd1;
                        state_q <= ST_SETUP;
                    end
                end else cnt_q <= cnt_q - 1'b1;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // unlock spacing timer restarts at each unlock issue
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap_q <= '0;
        else if (start && !unlock_early && pwdata[3:0] == OP_UNLOCK) gap_q <= CNT_W'(UNLOCK_GAP);
        else if (gap_q != '0) gap_q <= gap_q - 1'b1;
    end

    // read data captured at end of strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rdata_q <= 16'h0;
        else if (state_q == ST_STROBE && cnt_q == 1 && cyc_rd) rdata_q <= flash_dq_in;
    end

    // pins registered from sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_addr   <= 26'h0;
            flash_dq_out <= 16'h0;
            flash_dq_oe  <= 1'b0;
            flash_ce_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
        end else begin
            flash_addr   <= cyc_a;
            flash_dq_out <= cyc_d;
            flash_dq_oe  <= (state_q != ST_IDLE) && !cyc_rd && state_q != ST_GAP;
            flash_ce_n   <= !(state_q == ST_SETUP || state_q == ST_STROBE);
            flash_we_n   <= !(state_q == ST_STROBE && !cyc_rd);
            flash_oe_n   <= !(state_q == ST_STROBE && cyc_rd);
        end
    end

    // ************************
    // checks
    // ************************
    chk_no_both_strobes: assert property (@(posedge pclk) disable iff (!presetn)
        !(!flash_we_n && !flash_oe_n)) else $error("we and oe low together");
    chk_ce_with_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        (!flash_we_n || !flash_oe_n) |-> !flash_ce_n) else $error("strobe without ce");
    chk_unlock_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (start && pwdata[3:0] == OP_UNLOCK && gap_q != '0) |=> ctrl_q == $past(ctrl_q))
        else $error("early unlock accepted");
    chk_read_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_oe_n |-> !flash_dq_oe) else $error("driving dq during read");
    chk_drive_on_write: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_we_n |-> flash_dq_oe) else $error("dq not driven during write");
    chk_busy_ends: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(busy_q) |-> ##[1:200] !busy_q) else $error("sequence stuck");
    chk_enter_first: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(busy_q) && ctrl_q[3:0] == OP_ENTER) |-> ##2 flash_addr[15:0] == ADR_UNLOCK1)
        else $error("entry not at 555");
    chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (!flash_we_n && ctrl_q[3:0] == OP_EXIT) |-> flash_dq_out[15:8] == 8'h00)
        else $error("upper byte set");
    chk_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
        (start && !unlock_early && pwdata[3:0] == OP_UNLOCK) |=> gap_q == CNT_W'(UNLOCK_GAP))
        else $error("gap timer not loaded");
    cov_enter: cover property (@(posedge pclk) $rose(busy_q) && ctrl_q[3:0] == OP_ENTER);
    cov_unlock: cover property (@(posedge pclk) $rose(busy_q) && ctrl_q[3:0] == OP_UNLOCK);
    cov_read: cover property (@(posedge pclk) $rose(flash_oe_n));
    cov_refused: cover property (@(posedge pclk) $rose(refused_q));
endmodule : bpc_host
`default_nettype wire

// file: rtl/bpc_pkg.sv
// package for the block-protection command host controller
package bpc_pkg;
    // ********************************
    // device command words and addresses
    // ********************************
    localparam logic [15:0] ADR_UNLOCK1  = 16'h0555;
    localparam logic [15:0] ADR_UNLOCK2  = 16'h02aa;
    localparam logic [15:0] DAT_UNLOCK1  = 16'h00aa;
    localparam logic [15:0] DAT_UNLOCK2  = 16'h0055;
    localparam logic [7:0]  SET_LOCKREG  = 8'h40;
    localparam logic [7:0]  SET_PASSWORD = 8'h60;
    localparam logic [7:0]  SET_NVBITS   = 8'hc0;
    localparam logic [7:0]  SET_LOCKBIT  = 8'h50;
    localparam logic [7:0]  SET_VOLBITS  = 8'he0;
    localparam logic [7:0]  SET_EXTBLOCK = 8'h88;
    localparam logic [15:0] DAT_PROGRAM  = 16'h00a0;
    localparam logic [15:0] DAT_EXIT1    = 16'h0090;
    localparam logic [15:0] DAT_EXIT2    = 16'h0000;
    localparam logic [15:0] DAT_CLRALL1  = 16'h0080;
    localparam logic [15:0] DAT_CLRALL2  = 16'h0030;
    localparam logic [15:0] DAT_PROTECT  = 16'h0000;
    localparam logic [15:0] DAT_UNPROT   = 16'h0001;
    localparam logic [15:0] DAT_UNLK1    = 16'h0025;
    localparam logic [15:0] DAT_UNLK2    = 16'h0003;
    localparam logic [15:0] DAT_UNLK_END = 16'h0029;
    localparam logic [15:0] ADR_ZERO     = 16'h0000;
    // ********************************
    // apb register map (word aligned)
    // ********************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR   = 8'h04;
    localparam logic [7:0] OFF_WDATA  = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_RDATA  = 8'h10;
    localparam logic [7:0] OFF_PW0    = 8'h14;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // control opcodes written to ctrl[3:0]
    localparam logic [3:0] OP_ENTER  = 4'h1;  // ctrl[15:8] holds set code
    localparam logic [3:0] OP_PROG   = 4'h2;  // a0 then addr/wdata
    localparam logic [3:0] OP_READ   = 4'h3;  // one bus read at addr
    localparam logic [3:0] OP_EXIT   = 4'h4;
    localparam logic [3:0] OP_CLRALL = 4'h5;
    localparam logic [3:0] OP_UNLOCK = 4'h6;
    localparam logic [3:0] OP_RAW_WR = 4'h7;  // single write cycle
    // ********************************
    // timing
    // ********************************
    localparam int CLK_MHZ        = 250;
    localparam int UNLOCK_GAP_US  = 6;
    localparam int UNLOCK_GAP_CYC = UNLOCK_GAP_US * CLK_MHZ;
    localparam int STROBE_CYC     = 8;  // strobe low width per cycle
    localparam int IDLE_CYC       = 4;  // recovery between cycles
    localparam int CNT_W          = 16;
    localparam int SEQ_MAX        = 7;
endpackage : bpc_pkg

// file: tb/bpc_flash_model.sv
// behavioural flash partner that decodes the protection command sets
`timescale 1ns/10ps
`default_nettype none
module bpc_flash_model (
    input  wire logic [25:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    output logic      [15:0] flash_dq_in,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_oe_n
);
    // ********************************
    // write log and command state
    // ********************************
    logic [25:0] wa [64];
    logic [15:0] wd [64];
    int          wn = 0;
    int          rn = 0;
    logic [7:0]  mode = 8'h00;
    logic [7:0]  pend = 8'h00;
    int          st = 0;
    logic [15:0] lreg = 16'hffff;
    logic [15:0] rv;
    logic [15:0] lastv = 16'h0000;
    logic        nvlk = 1'b1;
    logic [3:0]  vol = 4'hf;
    logic [3:0]  nv = 4'hf;
    logic [1:0]  blk;
    logic [7:0]  dl;
    // lock-register bit that stands for the permanent password lock; position arbitrary
    localparam int PW_LOCK_BIT = 2;
    logic [15:0] pwm [4] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff};
    assign blk = flash_addr[17:16];  // any word of the block selects it
    assign dl = flash_dq_out[7:0];   // upper byte ignored
    // falling write strobe: address and data already placed by the host
    always @(negedge flash_we_n) begin
        if (!flash_ce_n) begin
            wa[wn[5:0]] = flash_addr;
            wd[wn[5:0]] = flash_dq_out;
            wn++;
            if (mode == 8'h00) begin
                // three-cycle entry
                if (flash_addr[15:0] == 16'h0555 && dl == 8'haa) st = 1;
                else if (st == 1 && flash_addr[15:0] == 16'h02aa && dl == 8'h55) st = 2;
                else if (st == 2 && flash_addr[15:0] == 16'h0555) begin
                    mode = dl;
                    st = 0;
                end else st = 0;
            end else if (pend != 8'h00) begin
                // second cycle of program, exit or clear-all
                case (pend)
                    8'ha0: begin
                        if (mode == 8'h40) lreg = flash_dq_out;
                        if (mode == 8'h50) nvlk = 1'b0;
                        if (mode == 8'hc0) nv[blk] = 1'b0;
                        if (mode == 8'he0) vol[blk] = flash_dq_out[0];
                        if (mode == 8'h60) pwm[flash_addr[1:0]] = flash_dq_out;
                    end
                    8'h90: if (dl == 8'h00) mode = 8'h00;
                    // all bits set first, then erased; refused while locked
                    8'h80: if (dl == 8'h30 && nvlk) begin
                        nv = 4'h0;
                        nv = 4'hf;
                    end
                    default: ;
                endcase
                pend = 8'h00;
            end else if (dl inside {8'ha0, 8'h90, 8'h80}) pend = dl;
            // read/reset and stray words dropped, mode kept
        end
    end
    // plain reads pick data by the entered command mode; array reads return a pattern of the address
    always_comb begin
        case (mode)
            8'h40: rv = lreg;
            8'h50: rv = {15'h0, nvlk};
            8'hc0: rv = {15'h0, nv[blk]};
            8'he0: rv = {15'h0, vol[blk]};
            // password hidden once the permanent lock bit is programmed
            8'h60: rv = lreg[PW_LOCK_BIT] ? pwm[flash_addr[1:0]] : 16'h0000;
            default: rv = 16'h5a00 ^ flash_addr[15:0];
        endcase
    end
    always @(negedge flash_oe_n) rn++;
    // a released bus shows the inverse of the last word, not a held copy
    always @(posedge flash_oe_n) lastv = rv;
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rv : ~lastv;
endmodule : bpc_flash_model
`default_nettype wire

// file: tb/test_bpc_host.sv
// self-checking bench for the protection command host controller
`timescale 1ns/10ps
`default_nettype none
module test_bpc_host;
    import bpc_pkg::*;
    // ********************************
    // signals, clock and instances
    // ********************************
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
    logic [25:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in;
    int          fails = 0, compares = 0, b, nr;
    logic [7:0]  codes [6] = '{SET_LOCKREG, SET_PASSWORD, SET_NVBITS, SET_LOCKBIT, SET_VOLBITS, SET_EXTBLOCK};
    always #2 pclk = ~pclk;
    bpc_host #(.UNLOCK_GAP(400)) u_bpc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
    bpc_flash_model u_bpc_flash_model (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
    // ********************************
    // access and compare tasks
    // ********************************
    // hold the request until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        cmp("pslverr", 32'h0, {31'h0, pslverr});
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // start an operation and wait for busy to drop
    task automatic run(input logic [3:0] op, input logic [7:0] c);
        apb(1'b1, OFF_CTRL, {16'h0, c, 4'h0, op});
        repeat (200) begin
            apb(1'b0, OFF_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        cmp("busy drop", 32'h0, {31'h0, rd[0]});
    endtask : run
    task automatic cyc(input int k, input logic [25:0] a, input logic [15:0] d);
        cmp("cycle addr", {6'h0, a}, {6'h0, u_bpc_flash_model.wa[(b + k) % 64]});
        cmp("cycle data", {16'h0, d}, {16'h0, u_bpc_flash_model.wd[(b + k) % 64]});
    endtask : cyc
    // load address and data, then run an operation that uses them
    task automatic op_at(input logic [3:0] op, input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, OFF_ADDR, a);
        apb(1'b1, OFF_WDATA, d);
        run(op, 8'h0);
    endtask : op_at
    // one plain read at an address, held against the expected word
    task automatic read_at(input string n, input logic [31:0] a, input logic [31:0] e);
        op_at(OP_READ, a, 32'h0);
        apb(1'b0, OFF_RDATA, 32'h0);
        cmp(n, e, rd);
    endtask : read_at
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // ********************************
    // tests
    // ********************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp("status reset", 32'h0, rd);
        apb(1'b0, OFF_PW0, 32'h0);
        cmp("pw0 reset", 32'h0000ffff, rd);
        apb(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 32'h0, rd);
        // every set entered and left; upper bits zero in command cycles
        foreach (codes[i]) begin
            b = u_bpc_flash_model.wn;
            run(OP_ENTER, codes[i]);
            cyc(0, 26'h555, 16'h00aa);
            cyc(1, 26'h2aa, 16'h0055);
            cyc(2, 26'h555, {8'h0, codes[i]});
            run(OP_EXIT, 8'h0);
            cmp("exit 1", 32'h90, {16'h0, u_bpc_flash_model.wd[(b + 3) % 64]});
            cmp("exit 2", 32'h00, {16'h0, u_bpc_flash_model.wd[(b + 4) % 64]});
            cmp("mode", 32'h0, {24'h0, u_bpc_flash_model.mode});
        end
        // lock register program then plain read; read/reset keeps the mode
        run(OP_ENTER, SET_LOCKREG);
        apb(1'b1, OFF_ADDR, 32'h0);
        apb(1'b1, OFF_WDATA, 32'h1234);
        b = u_bpc_flash_model.wn;
        run(OP_PROG, 8'h0);
        cyc(0, 26'h0, 16'h00a0);
        cyc(1, 26'h0, 16'h1234);
        nr = u_bpc_flash_model.rn;
        b = u_bpc_flash_model.wn;
        run(OP_READ, 8'h0);
        cmp("read writes", b, u_bpc_flash_model.wn);
        cmp("read cycles", nr + 1, u_bpc_flash_model.rn);
        apb(1'b0, OFF_RDATA, 32'h0);
        cmp("lock reg", 32'h1234, rd);
        apb(1'b1, OFF_WDATA, 32'hf0);
        run(OP_RAW_WR, 8'h0);
        cmp("mode kept", 32'h40, {24'h0, u_bpc_flash_model.mode});
        run(OP_EXIT, 8'h0);
        // volatile bit: program at one word of block 2, read at another
        run(OP_ENTER, SET_VOLBITS);
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, OFF_ADDR, 32'h0002_0010);
            apb(1'b1, OFF_WDATA, v);
            b = u_bpc_flash_model.wn;
            run(OP_PROG, 8'h0);
            cyc(1, 26'h2_0010, v[15:0]);
            apb(1'b1, OFF_ADDR, 32'h0002_fff0);
            run(OP_READ, 8'h0);
            apb(1'b0, OFF_RDATA, 32'h0);
            cmp("vol status", v, rd);
        end
        run(OP_EXIT, 8'h0);
        // protect a block, clear all, then lock the bits and retry the clear
        run(OP_ENTER, SET_NVBITS);
        op_at(OP_PROG, 32'h0001_0000, 32'(DAT_PROTECT));
        read_at("nv set", 32'h0001_8000, 32'h0);
        b = u_bpc_flash_model.wn;
        run(OP_CLRALL, 8'h0);
        cmp("clear 1", 32'h80, {16'h0, u_bpc_flash_model.wd[b % 64]});
        cyc(1, 26'h0, 16'h0030);
        read_at("nv cleared", 32'h0001_8000, 32'h1);
        run(OP_EXIT, 8'h0);
        run(OP_ENTER, SET_LOCKBIT);
        op_at(OP_PROG, 32'h0, 32'h0);
        read_at("lock bit", 32'h0, 32'h0);
        run(OP_EXIT, 8'h0);
        run(OP_ENTER, SET_NVBITS);
        op_at(OP_PROG, 32'h0001_0000, 32'(DAT_PROTECT));
        run(OP_CLRALL, 8'h0);
        read_at("clear refused", 32'h0001_8000, 32'h0);
        run(OP_EXIT, 8'h0);
        // unlock cycles, then a too-early second unlock is refused
        run(OP_ENTER, SET_PASSWORD);
        for (int i = 0; i < 4; i++) apb(1'b1, OFF_PW0 + 8'(4 * i), 32'h1111 * (i + 1));
        apb(1'b0, OFF_PW0 + 8'h0c, 32'h0);
        cmp("pw3", 32'h4444, rd);
        b = u_bpc_flash_model.wn;
        run(OP_UNLOCK, 8'h0);
        cyc(0, 26'h0, 16'h0025);
        cyc(1, 26'h0, 16'h0003);
        for (int i = 0; i < 4; i++) cyc(2 + i, 26'(i), 16'(16'h1111 * (i + 1)));
        cyc(6, 26'h0, 16'h0029);
        b = u_bpc_flash_model.wn;
        apb(1'b1, OFF_CTRL, {28'h0, OP_UNLOCK});
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp("refused", 32'h6, rd);
        repeat (200) begin
            apb(1'b0, OFF_STATUS, 32'h0);
            if (rd[2] === 1'b0) break;
        end
        cmp("gap ends", 32'h0, {31'h0, rd[2]});
        cmp("no cycles", b, u_bpc_flash_model.wn);
        run(OP_UNLOCK, 8'h0);
        cmp("accepted", b + 7, u_bpc_flash_model.wn);
        // one password word programmed and read back, then hidden by the lock
        op_at(OP_PROG, 32'h2, 32'hbeef);
        read_at("pw word", 32'h2, 32'hbeef);
        run(OP_EXIT, 8'h0);
        run(OP_ENTER, SET_LOCKREG);
        op_at(OP_PROG, 32'h0, 32'h1230);
        run(OP_EXIT, 8'h0);
        run(OP_ENTER, SET_PASSWORD);
        read_at("pw locked", 32'h2, 32'h0);
        run(OP_EXIT, 8'h0);
        close_out();
    end
    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        close_out();
    end
endmodule : test_bpc_host
`default_nettype wire
